// file: pkg/ist_pkg.sv
// Purpose: shared types of the idle/standby command block
// Assumes: nothing
// Notes: constants live in ist_regs.svh
package ist_pkg;
  typedef enum logic [0:0] {ST_WAIT, ST_EXEC} ist_state_t;
  typedef enum logic [1:0] {MODE_ACTIVE, MODE_IDLE, MODE_STANDBY} ist_mode_t;
endpackage

// file: pkg/ist_regs.svh
`ifndef IST_REGS_SVH
`define IST_REGS_SVH
// Register byte offsets
`define IST_OFF_ERROR 8'h00
`define IST_OFF_SECTOR_COUNT 8'h04
`define IST_OFF_DEVICE_HEAD 8'h08
`define IST_OFF_COMMAND 8'h0C
`define IST_OFF_STATUS 8'h10
`define IST_OFF_CONFIG 8'h14
`define IST_OFF_PARAMS 8'h18
`define IST_OFF_TIMER 8'h1C
// Status bit positions
`define IST_ST_BSY 7
`define IST_ST_DRDY 6
`define IST_ST_DF 5
`define IST_ST_DRQ 3
`define IST_ST_ERR 0
// Error and device/head bit positions
`define IST_ER_ABRT 2
`define IST_DH_DEV 4
// Config bit positions
`define IST_CFG_PM 0
`define IST_CFG_PACKET 1
`define IST_CFG_CHS 2
`define IST_CFG_FAULT 3
`define IST_CFG_DEV 4
// Reset values
`define IST_CONFIG_RESET 8'h05
`define IST_BYTE_RESET 8'h00
// Opcodes
`define IST_OP_IDLE 8'hE3
`define IST_OP_IDLE_NOW 8'hE1
`define IST_OP_INIT_PARAMS 8'h91
// Standby timer codes
`define IST_CODE_OFF 8'h00
`define IST_CODE_SHORT_MAX 8'hF0
`define IST_CODE_LONG_MAX 8'hFB
`define IST_CODE_21MIN 8'hFC
`define IST_CODE_LONGEST 8'hFD
`define IST_CODE_RSVD 8'hFE
// Standby periods in seconds, and the long-range code base
`define IST_SHORT_STEP_S 16'h0005
`define IST_LONG_BASE 16'h00F0
`define IST_LONG_STEP_S 16'h0708
`define IST_21MIN_S 16'h04EC
`define IST_21MIN15_S 16'h04FB
`define IST_LONGEST_S 16'h8CA0
// Timing
`define IST_CLK_PERIOD_NS 100
`define IST_TICK_TIME_MS 1000
`endif

// file: verification/ist_host_model.sv
// Purpose: host adapter model driving the task-file registers over APB
// Assumes: slave finishes the access phase when pready is high
// Notes: released address and data show the inverse of the last value
`include "ist_regs.svh"
module ist_host_model (
  input wire logic i_core_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int timeouts = 0;
  logic [31:0] rd_q;
  logic err_q;

  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h00000000;
  end

  // Pre-edge copies, so the answer is the one at the sampling edge
  always @(posedge i_core_clk)
  begin
    rd_q <= i_prdata;
    err_q <= i_pslverr;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    @(posedge i_core_clk);
    while (i_pready !== 1'b1 && n < 64)
    begin
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 64)
      timeouts++;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
    #1;
    r = rd_q;
    e = err_q;
  endtask

  task automatic issue(input logic [7:0] op, input logic [7:0] dh);
    logic [31:0] r;
    logic e;
    int n;
    xfer(1'b1, `IST_OFF_DEVICE_HEAD, {24'h000000, dh}, r, e);
    n = 0;
    do
    begin
      xfer(1'b0, `IST_OFF_STATUS, 32'h00000000, r, e);
      n++;
    end
    while (r[`IST_ST_DRDY] !== 1'b1 && n < 16);
    if (n >= 16)
      timeouts++;
    xfer(1'b1, `IST_OFF_COMMAND, {24'h000000, op}, r, e);
  endtask
endmodule

// file: verification/ist_tb.sv
// Purpose: self-checking bench for the idle/standby command block
// Assumes: TICK_CYCLES shortened to 10, completion two edges after command
// Notes: status reads also clear the interrupt, so intrq is looked at first
`include "ist_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, intrq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  ist_pkg::ist_mode_t mode;
  int fail_count = 0;
  int check_count = 0;

  initial
  begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  ist_cmd #(.TICK_CYCLES(10)) DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_intrq(intrq), .o_power_mode(mode));
  ist_host_model HOST (.i_core_clk(i_core_clk), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata));

  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic guard;
    if (HOST.timeouts != 0)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    HOST.xfer(1'b0, a, 32'h00000000, r, e);
    guard();
    chk(nm, exp, r & m);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    HOST.xfer(1'b1, a, {24'h000000, d}, r, e);
    guard();
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] dh);
    HOST.issue(op, dh);
    guard();
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic e;
    chk("mode", 32'h00000000, {30'h0, mode});
    rd(`IST_OFF_CONFIG, 32'h000000FF, 32'h00000005, "config");
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000000, "error");
    wr(`IST_OFF_STATUS, 8'hFF);
    rd(`IST_OFF_STATUS, 32'hFFFFFFFF, 32'h00000040, "status");
    HOST.xfer(1'b0, 8'h20, 32'h00000000, r, e);
    chk("unmapped_data", 32'h00000000, r);
    chk("unmapped_err", 32'h00000001, {31'h0, e});
  endtask

  task automatic t_codes;
    logic [7:0] codes [8] = '{8'h01, 8'hF0, 8'hF1, 8'hFB, 8'hFC, 8'hFD, 8'hFF, 8'h0C};
    logic [15:0] secs [8] = '{16'h0005, 16'h04B0, 16'h0708, 16'h4D58, 16'h04EC, 16'h8CA0, 16'h04FB, 16'h003C};
    for (int i = 0; i < 8; i++)
    begin
      wr(`IST_OFF_SECTOR_COUNT, codes[i]);
      cmd(`IST_OP_IDLE, 8'h00);
      chk("intrq", 32'h00000001, {31'h0, intrq});
      rd(`IST_OFF_TIMER, 32'h0301FFFF, {16'h0101, secs[i]}, "timer");
      rd(`IST_OFF_STATUS, 32'hFFFFFFFF, 32'h00000040, "status");
    end
    chk("intrq", 32'h00000000, {31'h0, intrq});
    wr(`IST_OFF_SECTOR_COUNT, 8'h00);
    cmd(`IST_OP_IDLE, 8'h00);
    rd(`IST_OFF_TIMER, 32'h03010000, 32'h01000000, "timer_off");
    wr(`IST_OFF_SECTOR_COUNT, 8'hFE);
    cmd(`IST_OP_IDLE, 8'h00);
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000004, "error");
    rd(`IST_OFF_STATUS, 32'hFFFFFFFF, 32'h00000041, "status");
    cmd(8'h00, 8'h00);
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000004, "error");
  endtask

  task automatic t_standby;
    int n;
    wr(`IST_OFF_SECTOR_COUNT, 8'h01);
    cmd(`IST_OP_IDLE, 8'h00);
    chk("mode", 32'h00000001, {30'h0, mode});
    n = 0;
    while (mode !== ist_pkg::MODE_STANDBY && n < 100)
    begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    if (n >= 100)
    begin
      fail_count++;
      tally_and_finish();
    end
    chk("mode", 32'h00000002, {30'h0, mode});
    wr(`IST_OFF_SECTOR_COUNT, 8'hFE);
    cmd(`IST_OP_IDLE_NOW, 8'h00);
    chk("mode", 32'h00000001, {30'h0, mode});
    rd(`IST_OFF_TIMER, 32'h0301FFFF, 32'h01010005, "timer");
    rd(`IST_OFF_STATUS, 32'hFFFFFFFF, 32'h00000040, "status");
  endtask

  task automatic t_no_pm;
    wr(`IST_OFF_CONFIG, 8'h04);
    wr(`IST_OFF_SECTOR_COUNT, 8'h0C);
    cmd(`IST_OP_IDLE, 8'h00);
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000004, "error");
    rd(`IST_OFF_STATUS, 32'hFFFFFFFF, 32'h00000041, "status");
    cmd(`IST_OP_IDLE_NOW, 8'h00);
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000004, "error");
    rd(`IST_OFF_TIMER, 32'h0301FFFF, 32'h01010005, "timer");
    wr(`IST_OFF_CONFIG, 8'h05);
  endtask

  task automatic t_init;
    wr(`IST_OFF_SECTOR_COUNT, 8'h3F);
    cmd(`IST_OP_INIT_PARAMS, 8'h0F);
    rd(`IST_OFF_PARAMS, 32'hFFFFFFFF, 32'h00000F3F, "params");
    rd(`IST_OFF_STATUS, 32'hFFFFFFFF, 32'h00000040, "status");
    wr(`IST_OFF_CONFIG, 8'h07);
    wr(`IST_OFF_SECTOR_COUNT, 8'h11);
    cmd(`IST_OP_INIT_PARAMS, 8'h05);
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000004, "error");
    rd(`IST_OFF_PARAMS, 32'hFFFFFFFF, 32'h00000F3F, "params");
    wr(`IST_OFF_CONFIG, 8'h05);
  endtask

  task automatic t_fault;
    wr(`IST_OFF_CONFIG, 8'h0D);
    cmd(`IST_OP_IDLE_NOW, 8'h00);
    rd(`IST_OFF_STATUS, 32'hFFFFFFFF, 32'h00000061, "status");
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000004, "error");
    wr(`IST_OFF_CONFIG, 8'h05);
    cmd(`IST_OP_IDLE_NOW, 8'h00);
    rd(`IST_OFF_STATUS, 32'hFFFFFFFF, 32'h00000040, "status");
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000000, "error");
    cmd(8'h00, 8'h10);
    chk("intrq", 32'h00000000, {31'h0, intrq});
    rd(`IST_OFF_ERROR, 32'hFFFFFFFF, 32'h00000000, "error");
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    t_reset();
    t_codes();
    t_standby();
    t_no_pm();
    t_init();
    t_fault();
    tally_and_finish();
  end
endmodule

// file: verilog/ist_cmd.sv
// Purpose: idle, idle-now and init-parameters command handling behind APB task-file registers
// Assumes: APB3 slave, zero wait states, one clock at 10 MHz
// Notes: commands take one busy cycle; INTRQ clears on status read or next command
// How it works
// R1 - Opcode E3h loads standby period from sector count, then enters Idle.
// R2 - Non-zero count enables the standby timer, zero disables it.
// R3 - Codes 01h-F0h give code times 5 s; FCh 21 min; FFh 21 min 15 s.
// R4 - Codes F1h-FBh give (code minus 240) times 30 minutes.
// R5 - Code FDh gives ten hours; reserved FEh is aborted.
// R6 - Idle command puts device in Idle with the timer as programmed.
// R7 - Opcode E1h enters Idle at once, ignoring sector count and features.
// R8 - INTRQ raised at completion, in the same cycle as the mode change.
// R9 - Good completion clears BSY, DF, DRQ, ERR and sets DRDY.
// R10 - Without power management, idle commands abort with error bit 2.
// R11 - Abort bit also set when the requested action cannot be done.
// R12 - Error completion sets DF on fault, clears BSY and DRQ, sets DRDY.
// R13 - ERR in status set whenever any error bit is set.
// R14 - Host issues idle commands only while DRDY is set.
// R15 - Host selects the device with bit 4 of device/head.
// R16 - Opcode 91h stores sectors per track and low-nibble max head.
// R17 - Packet devices abort 91h; CHS-capable devices accept it.
// R18 - All three commands are non-data; DRQ never rises.
// R19 - Expired enabled timer moves Idle to Standby; any command restarts it.
//
// Our own choices: the APB slave port and the register offsets.
`include "ist_regs.svh"
module ist_cmd #(
  parameter int TICK_CYCLES = (`IST_TICK_TIME_MS * 1000000) / `IST_CLK_PERIOD_NS
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_intrq,
  output ist_pkg::ist_mode_t o_power_mode
);
  logic [7:0] sector_count_reg;
  logic [7:0] device_head_reg;
  logic [7:0] config_reg;
  logic [7:0] cmd_op_reg;
  logic [7:0] error_reg;
  logic [7:0] error_next;
  logic [7:0] spt_reg;
  logic [3:0] max_head_reg;
  logic [31:0] prdata_reg;
  ist_pkg::ist_state_t state_reg;
  ist_pkg::ist_mode_t mode_reg;
  logic bsy_reg;
  logic drdy_reg;
  logic df_reg;
  logic err_reg;
  logic intrq_reg;
  logic slverr_reg;
  logic setup_w;
  logic wr_acc_w;
  logic rd_acc_w;
  logic mapped_w;
  logic cmd_accept_w;
  logic exec_w;
  logic op_idle_w;
  logic op_init_w;
  logic abort_w;
  logic load_w;
  logic expired_w;
  logic timer_en_w;
  logic [15:0] left_s_w;
  logic [15:0] period_w;
  logic [7:0] status_w;
  // R3 R4 R5 code to seconds
  function automatic logic [15:0] period_of(input logic [7:0] code);
    logic [15:0] c;
    begin
      c = {8'h00, code};
      if (code <= `IST_CODE_SHORT_MAX)
        period_of = c * `IST_SHORT_STEP_S;
      else if (code <= `IST_CODE_LONG_MAX)
        period_of = (c - `IST_LONG_BASE) * `IST_LONG_STEP_S;
      else if (code == `IST_CODE_21MIN)
        period_of = `IST_21MIN_S;
      else if (code == `IST_CODE_LONGEST)
        period_of = `IST_LONGEST_S;
      else
        period_of = `IST_21MIN15_S;
    end
  endfunction

  assign setup_w = i_psel & ~i_penable;
  assign wr_acc_w = i_psel & i_penable & i_pwrite;
  assign rd_acc_w = i_psel & i_penable & ~i_pwrite;

  always_comb
  begin
    if (i_paddr == `IST_OFF_ERROR || i_paddr == `IST_OFF_SECTOR_COUNT || i_paddr == `IST_OFF_DEVICE_HEAD)
      mapped_w = 1'b1;
    else if (i_paddr == `IST_OFF_COMMAND || i_paddr == `IST_OFF_STATUS || i_paddr == `IST_OFF_CONFIG)
      mapped_w = 1'b1;
    else if (i_paddr == `IST_OFF_PARAMS || i_paddr == `IST_OFF_TIMER)
      mapped_w = 1'b1;
    else
      mapped_w = 1'b0;
  end

  // R15 answer only our DEV
  assign cmd_accept_w = wr_acc_w & (i_paddr == `IST_OFF_COMMAND) & (state_reg == ist_pkg::ST_WAIT)
    & (device_head_reg[`IST_DH_DEV] == config_reg[`IST_CFG_DEV]);
  assign exec_w = (state_reg == ist_pkg::ST_EXEC);
  assign op_idle_w = (cmd_op_reg == `IST_OP_IDLE) | (cmd_op_reg == `IST_OP_IDLE_NOW);
  assign op_init_w = (cmd_op_reg == `IST_OP_INIT_PARAMS);

  // R5 R10 R11 R17 abort causes
  always_comb
  begin
    abort_w = config_reg[`IST_CFG_FAULT];
    if (op_idle_w)
    begin
      if (!config_reg[`IST_CFG_PM] || !drdy_reg)
        abort_w = 1'b1;
      if (cmd_op_reg == `IST_OP_IDLE && sector_count_reg == `IST_CODE_RSVD)
        abort_w = 1'b1;
    end
    else if (op_init_w)
    begin
      if (config_reg[`IST_CFG_PACKET] || !config_reg[`IST_CFG_CHS])
        abort_w = 1'b1;
    end
    else
      abort_w = 1'b1;
    error_next = `IST_BYTE_RESET;
    error_next[`IST_ER_ABRT] = abort_w;
  end

  // R1 R7 only E3h uses the count
  assign load_w = exec_w & (cmd_op_reg == `IST_OP_IDLE) & ~abort_w;
  assign period_w = period_of(sector_count_reg);

  ist_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .SEC_W(16)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_load(load_w),
    .i_enable(sector_count_reg != `IST_CODE_OFF),
    .i_period_s(period_w),
    .i_restart(cmd_accept_w),
    .i_run(mode_reg != ist_pkg::MODE_STANDBY),
    .o_expired(expired_w),
    .o_enabled(timer_en_w),
    .o_left_s(left_s_w)
  );

  // Task-file inputs are frozen while busy
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      sector_count_reg <= `IST_BYTE_RESET;
      device_head_reg <= `IST_BYTE_RESET;
      config_reg <= `IST_CONFIG_RESET;
    end
    else if (wr_acc_w && !bsy_reg)
    begin
      if (i_paddr == `IST_OFF_SECTOR_COUNT)
        sector_count_reg <= i_pwdata[7:0];
      else if (i_paddr == `IST_OFF_DEVICE_HEAD)
        device_head_reg <= i_pwdata[7:0];
      else if (i_paddr == `IST_OFF_CONFIG)
        config_reg <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ist_pkg::ST_WAIT;
      cmd_op_reg <= `IST_BYTE_RESET;
    end
    else
    begin
      case (state_reg)
        ist_pkg::ST_WAIT:
        begin
          if (cmd_accept_w)
          begin
            cmd_op_reg <= i_pwdata[7:0];
            state_reg <= ist_pkg::ST_EXEC;
          end
        end
        default:
          state_reg <= ist_pkg::ST_WAIT;
      endcase
    end
  end

  // R9 R12 R13 completion status
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      bsy_reg <= 1'b0;
      drdy_reg <= 1'b0;
      df_reg <= 1'b0;
      err_reg <= 1'b0;
      error_reg <= `IST_BYTE_RESET;
    end
    else if (cmd_accept_w)
      bsy_reg <= 1'b1;
    else if (exec_w)
    begin
      bsy_reg <= 1'b0;
      drdy_reg <= 1'b1;
      df_reg <= config_reg[`IST_CFG_FAULT];
      error_reg <= error_next;
      err_reg <= |error_next;
    end
    else
      drdy_reg <= 1'b1;
  end

  // R8 INTRQ at completion, set beats clear
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      intrq_reg <= 1'b0;
    else if (exec_w)
      intrq_reg <= 1'b1;
    else if (cmd_accept_w || (rd_acc_w && i_paddr == `IST_OFF_STATUS))
      intrq_reg <= 1'b0;
  end

  // R6 R7 R19 power mode
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      mode_reg <= ist_pkg::MODE_ACTIVE;
    else if (exec_w && op_idle_w && !abort_w)
      mode_reg <= ist_pkg::MODE_IDLE;
    else if (expired_w)
      mode_reg <= ist_pkg::MODE_STANDBY;
  end

  // R16 geometry capture
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      spt_reg <= `IST_BYTE_RESET;
      max_head_reg <= 4'h0;
    end
    else if (exec_w && op_init_w && !abort_w)
    begin
      spt_reg <= sector_count_reg;
      max_head_reg <= device_head_reg[3:0];
    end
  end

  // R18 no data phase, DRQ held low
  always_comb
  begin
    status_w = `IST_BYTE_RESET;
    status_w[`IST_ST_BSY] = bsy_reg;
    status_w[`IST_ST_DRDY] = drdy_reg;
    status_w[`IST_ST_DF] = df_reg;
    status_w[`IST_ST_DRQ] = 1'b0;
    status_w[`IST_ST_ERR] = err_reg;
  end

  // Read data sampled in setup so pready can stay high
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end
    else if (setup_w)
    begin
      slverr_reg <= ~mapped_w;
      if (i_pwrite)
        prdata_reg <= 32'h0000_0000;
      else if (i_paddr == `IST_OFF_ERROR)
        prdata_reg <= {24'h00_0000, error_reg};
      else if (i_paddr == `IST_OFF_SECTOR_COUNT)
        prdata_reg <= {24'h00_0000, sector_count_reg};
      else if (i_paddr == `IST_OFF_DEVICE_HEAD)
        prdata_reg <= {24'h00_0000, device_head_reg};
      else if (i_paddr == `IST_OFF_STATUS)
        prdata_reg <= {24'h00_0000, status_w};
      else if (i_paddr == `IST_OFF_CONFIG)
        prdata_reg <= {24'h00_0000, config_reg};
      else if (i_paddr == `IST_OFF_PARAMS)
        prdata_reg <= {20'h0_0000, max_head_reg, spt_reg};
      else if (i_paddr == `IST_OFF_TIMER)
        prdata_reg <= {6'h00, mode_reg, 7'h00, timer_en_w, left_s_w};
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & slverr_reg;
  assign o_intrq = intrq_reg;
  assign o_power_mode = mode_reg;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_SHORT_CODE: assert property ( // R3
    (load_w && sector_count_reg == 8'h0C) |=> timer_en_w && left_s_w == 16'h003C)
    else $error("Code 0Ch did not give 60 s");
  AST_LONG_CODE: assert property ( // R4
    (load_w && sector_count_reg == 8'hF2) |=> left_s_w == 16'h0E10)
    else $error("Code F2h did not give one hour");
  AST_FD_RANGE: assert property ( // R5
    (load_w && sector_count_reg == `IST_CODE_LONGEST) |=> left_s_w >= 16'h7080 && left_s_w <= 16'hA8C0)
    else $error("Code FDh outside 8 to 12 hours");
  AST_RSVD_ABORT: assert property ( // R5
    (exec_w && cmd_op_reg == `IST_OP_IDLE && sector_count_reg == `IST_CODE_RSVD) |=> error_reg[`IST_ER_ABRT])
    else $error("Reserved code not aborted");
  AST_TIMER_OFF: assert property ( // R2
    (load_w && sector_count_reg == `IST_CODE_OFF) |=> !timer_en_w ##1 !expired_w [*3])
    else $error("Zero count left timer running");
  AST_IDLE_ENTRY: assert property ( // R7
    (cmd_accept_w && i_pwdata[7:0] == `IST_OP_IDLE_NOW && config_reg[`IST_CFG_PM] && drdy_reg
      && !config_reg[`IST_CFG_FAULT]) |=> ##1 mode_reg == ist_pkg::MODE_IDLE)
    else $error("Idle-now did not reach Idle");
  AST_INTRQ_DONE: assert property ( // R8
    cmd_accept_w |=> bsy_reg && !o_intrq ##1 !bsy_reg && o_intrq)
    else $error("INTRQ not raised at completion");
  AST_GOOD_STATUS: assert property ( // R9
    (exec_w && !abort_w) |=> status_w == 8'h40 && error_reg == 8'h00)
    else $error("Bad status after good completion");
  AST_PM_ABORT: assert property ( // R10
    (exec_w && op_idle_w && !config_reg[`IST_CFG_PM]) |=> error_reg == 8'h04 && mode_reg == $past(mode_reg))
    else $error("Idle without power management not aborted");
  AST_FAULT_DF: assert property ( // R12
    (exec_w && config_reg[`IST_CFG_FAULT]) |=> df_reg && drdy_reg && !bsy_reg && !status_w[`IST_ST_DRQ])
    else $error("Fault completion status wrong");
  AST_ERR_MIRROR: assert property ( // R13
    !bsy_reg |-> err_reg == (error_reg != 8'h00))
    else $error("ERR disagrees with error register");
  AST_GEOMETRY: assert property ( // R16
    (exec_w && op_init_w && !abort_w) |=> spt_reg == $past(sector_count_reg)
      && max_head_reg == $past(device_head_reg[3:0]))
    else $error("Geometry not captured");
  AST_PACKET_91: assert property ( // R17
    (exec_w && op_init_w && config_reg[`IST_CFG_PACKET]) |=> error_reg[`IST_ER_ABRT] && $stable(spt_reg))
    else $error("Packet device accepted 91h");
  AST_STANDBY: assert property ( // R19
    (expired_w && !exec_w) |=> mode_reg == ist_pkg::MODE_STANDBY)
    else $error("Expiry did not enter Standby");

  COV_IDLE_TIMER: cover property (load_w && sector_count_reg != `IST_CODE_OFF);
  COV_IDLE_NOW: cover property (exec_w && cmd_op_reg == `IST_OP_IDLE_NOW && !abort_w);
  COV_INIT_OK: cover property (exec_w && op_init_w && !abort_w);
  COV_STANDBY: cover property (expired_w);
endmodule

// file: verilog/ist_timer.sv
// Purpose: standby timer counting whole seconds
// Assumes: period is loaded non-zero whenever enabled
// Notes: one-second prescaler, cleared on load and restart, so periods are exact to a clock
module ist_timer #(
  parameter int TICK_CYCLES = 10000000,
  parameter int SEC_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic i_enable,
  input wire logic [SEC_W-1:0] i_period_s,
  input wire logic i_restart,
  input wire logic i_run,
  output logic o_expired,
  output logic o_enabled,
  output logic [SEC_W-1:0] o_left_s
);
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic [PRE_W-1:0] pre_reg;
  logic [SEC_W-1:0] left_reg;
  logic [SEC_W-1:0] period_reg;
  logic en_reg;
  logic expired_reg;
  logic tick_w;
  logic count_w;

  assign tick_w = (pre_reg == PRE_LAST);
  assign count_w = en_reg & i_run & (left_reg != '0);

  // R2 enable follows count
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      en_reg <= 1'b0;
      period_reg <= '0;
    end
    else if (i_load)
    begin
      en_reg <= i_enable;
      period_reg <= i_period_s;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      pre_reg <= '0;
    else if (i_load || i_restart || !count_w || tick_w)
      pre_reg <= '0;
    else
      pre_reg <= pre_reg + 1'b1;
  end

  // R19 restart on activity
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      left_reg <= '0;
    else if (i_load)
      left_reg <= i_period_s;
    else if (i_restart)
      left_reg <= period_reg;
    else if (count_w && tick_w)
      left_reg <= left_reg - 1'b1;
  end

  // R19 expiry pulse
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      expired_reg <= 1'b0;
    else
      expired_reg <= count_w & tick_w & (left_reg == SEC_W'(1)) & ~i_load & ~i_restart;
  end

  assign o_expired = expired_reg;
  assign o_enabled = en_reg;
  assign o_left_s = left_reg;

  AST_EXPIRE_NEEDS_EN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R19
    o_expired |-> $past(en_reg) && left_reg == '0)
    else $error("Timer expired while disabled");
  AST_RESTART_RELOAD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R19
    (i_restart && !i_load) |=> (left_reg == $past(period_reg)) && !o_expired)
    else $error("Restart did not reload the period");
endmodule
